// ===== rtl/pdmi_top.v
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "pdmi_defs.vh"

// Notes on behaviour
// RULE_01 - device drives the bit clock and takes one data input, mono or stereo
// RULE_02 - two microphones, left and right, share that single data input
// RULE_03 - output samples are 16 bits at nominal 16 kHz
// RULE_04 - decimation by 64 or 80 selectable; software retunes the clock divider
// RULE_05 - clock divider field sets bit clock frequency
// RULE_06 - bit clock is a plain fixed division of the source clock, no added jitter
// RULE_07 - default: left captured on falling edge, right on rising edge
// RULE_08 - edge swap: left on rising edge, right on falling edge
// RULE_09 - each channel has its own decimation filter to 16-bit PCM
// RULE_10 - samples are written to one RAM buffer by the DMA port
// RULE_11 - stereo stores left/right pairs, mono stores only left samples
// RULE_12 - software loads next pointer before current buffer fills
// RULE_13 - START begins continuous transfer, STOP ends it
// RULE_14 - STOP takes effect after the current frame, then STOPPED
// RULE_15 - STOPPED only once final DMA write has completed
// RULE_16 - software waits for STOPPED before a new START
// RULE_17 - per-channel volume stage spans 20 dB either side of reset gain
// RULE_18 - volume is in 0.5 dB steps around the default gain
// RULE_19 - software keeps volume within lowest and highest limits
// RULE_20 - buffer pointer is double-buffered, taken when current buffer fills
// RULE_21 - full buffer raises END, continues in new buffer, raises STARTED
// RULE_22 - buffer count is in 16-bit samples, two bytes each
// RULE_23 - signed 16-bit samples, little endian, left in lower half
// RULE_24 - volume stage saturates instead of wrapping
module pdmi_top #(
   parameter CW = 24,                 // decimator accumulator width
   parameter NW = 16                  // buffer sample count width
) (
   input  wire        hclk,           // bus and core clock
   input  wire        hresetn,        // async reset, active low
   input  wire        hsel,           // slave select
   input  wire [31:0] haddr,          // byte address
   input  wire [1:0]  htrans,         // transfer type
   input  wire        hwrite,         // write not read
   input  wire [2:0]  hsize,          // transfer size, word only
   input  wire [31:0] hwdata,         // write data
   input  wire        hready,         // bus ready in
   output wire [31:0] hrdata,         // read data
   output wire        hreadyout,      // slave ready
   output wire        hresp,          // always okay
   input  wire        mic_data_in,    // shared microphone data pin
   output wire        mic_bit_clock,  // bit clock to microphones
   output wire        dma_req,        // word write request
   output wire [31:0] dma_addr,       // byte address of word
   output wire [31:0] dma_wdata,      // word to store
   input  wire        dma_ack         // memory took the word
);

   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_RUN  = 3'b010;
   localparam [2:0] S_STOP = 3'b100;

   reg  [31:0]     hrdata_q;
   reg             hreadyout_q;
   reg             hresp_q;
   reg             wr_q;
   reg  [11:0]     wa_q;
   reg  [31:0]     rmux;
   reg             en_q;
   reg  [7:0]      div_sel_q;
   reg             mono_q;
   reg             edge_q;
   reg  [6:0]      lvol_q;
   reg  [6:0]      rvol_q;
   reg             r80_q;
   reg  [31:0]     ptr_q;
   reg  [NW-1:0]   cnt_q;
   reg             ev_st_q;
   reg             ev_sp_q;
   reg             ev_end_q;
   reg  [2:0]      st_q;
   reg  [7:0]      div_q;
   reg             bclk_q;
   reg             rise_q;
   reg             fall_q;
   reg             s1_q;
   reg             s2_q;
   reg             s3_q;
   reg             din_q;
   reg  [6:0]      dc_q;
   reg             dec_q;
   reg             pv_q;
   reg             gv_q;
   reg  [31:0]     cur_q;
   reg  [NW:0]     scnt_q;
   reg             half_q;
   reg  [15:0]     lsave_q;
   reg             dma_req_q;
   reg  [31:0]     dma_addr_q;
   reg  [31:0]     dma_wdata_q;
   wire [31:0]     gpair;

   // clamp a wide value into the signed 16-bit range
   function [15:0] sat16;
      input [35:0] v;
      begin
         if (v[35:15] != {21{v[35]}})
            sat16 = v[35] ? 16'h8000 : 16'h7fff; // RULE_24
         else
            sat16 = v[15:0];
      end
   endfunction

   // volume: 12 half-dB steps per 6 dB octave, table holds 2^(k/12) in q12
   function [35:0] gmul;
      input [15:0] s;
      input [6:0]  g;
      reg   [6:0]  gc;
      reg   [6:0]  idx;
      reg   [6:0]  q;
      reg   [6:0]  r;
      reg   [12:0] m;
      reg signed [35:0] p;
      begin
         gc  = (g > `PDMI_VOL_MAX) ? `PDMI_VOL_MAX : g; // RULE_19
         idx = gc + `PDMI_VOL_OFS;
         q   = idx / 7'h0c;
         r   = idx % 7'h0c;
         case (r[3:0]) // RULE_18
            4'h0: m = 13'h1000;
            4'h1: m = 13'h10f4;
            4'h2: m = 13'h11f6;
            4'h3: m = 13'h1307;
            4'h4: m = 13'h1429;
            4'h5: m = 13'h155c;
            4'h6: m = 13'h16a1;
            4'h7: m = 13'h17f9;
            4'h8: m = 13'h1966;
            4'h9: m = 13'h1ae9;
            4'ha: m = 13'h1c82;
            default: m = 13'h1e34;
         endcase
         p    = $signed(s) * $signed({1'b0, m});
         gmul = (p <<< q[2:0]) >>> 16; // RULE_17
      end
   endfunction

   wire ap      = hsel & htrans[1] & hready;
   wire start_p = wr_q & (wa_q == `PDMI_A_START) & hwdata[0];
   wire stop_p  = wr_q & (wa_q == `PDMI_A_STOP) & hwdata[0];
   wire run     = ~st_q[0];

   // read mux, sampled in the address phase
   always @* begin
      case (haddr[11:0])
         `PDMI_A_EVSTART: rmux = {31'h0, ev_st_q};
         `PDMI_A_EVSTOP:  rmux = {31'h0, ev_sp_q};
         `PDMI_A_EVEND:   rmux = {31'h0, ev_end_q};
         `PDMI_A_STATUS:  rmux = {29'h0, st_q};
         `PDMI_A_ENABLE:  rmux = {31'h0, en_q};
         `PDMI_A_CLKDIV:  rmux = {24'h0, div_sel_q};
         `PDMI_A_MODE:    rmux = {30'h0, edge_q, mono_q};
         `PDMI_A_LVOL:    rmux = {25'h0, lvol_q};
         `PDMI_A_RVOL:    rmux = {25'h0, rvol_q};
         `PDMI_A_RATIO:   rmux = {31'h0, r80_q};
         `PDMI_A_PTR:     rmux = ptr_q;
         `PDMI_A_CNT:     rmux = {{(32-NW){1'b0}}, cnt_q};
         default:         rmux = 32'h0;
      endcase
   end

   // bus slave: zero wait states, always okay
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q    <= 32'h0;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
         wr_q        <= 1'b0;
         wa_q        <= 12'h0;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
         wr_q        <= ap & hwrite;
         wa_q        <= haddr[11:0];
         hrdata_q    <= (ap & ~hwrite) ? rmux : 32'h0;
      end
   end

   // configuration registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_q      <= 1'b0;
         div_sel_q <= `PDMI_CLKDIV_RST;
         mono_q    <= 1'b0;
         edge_q    <= 1'b0;
         lvol_q    <= `PDMI_VOL_RST;
         rvol_q    <= `PDMI_VOL_RST;
         r80_q     <= `PDMI_RATIO_RST;
         ptr_q     <= 32'h0;
         cnt_q     <= {NW{1'b0}};
      end else if (wr_q) begin
         case (wa_q)
            `PDMI_A_ENABLE: en_q <= hwdata[0];
            `PDMI_A_CLKDIV: div_sel_q <= hwdata[7:0]; // RULE_05
            `PDMI_A_MODE: begin
               mono_q <= hwdata[`PDMI_MODE_MONO];
               edge_q <= hwdata[`PDMI_MODE_EDGE];
            end
            `PDMI_A_LVOL:   lvol_q <= hwdata[6:0];
            `PDMI_A_RVOL:   rvol_q <= hwdata[6:0];
            `PDMI_A_RATIO:  r80_q <= hwdata[0]; // RULE_04
            `PDMI_A_PTR:    ptr_q <= hwdata; // RULE_20
            `PDMI_A_CNT:    cnt_q <= hwdata[NW-1:0];
            default: ;
         endcase
      end
   end

   // bit clock: fixed division of hclk, low while idle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q  <= 8'h0;
         bclk_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else if (!run) begin
         div_q  <= 8'h0;
         bclk_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else if (div_q + 8'h01 >= div_sel_q) begin
         div_q  <= 8'h0;
         bclk_q <= ~bclk_q; // RULE_01 RULE_06
         rise_q <= ~bclk_q;
         fall_q <= bclk_q;
      end else begin
         div_q  <= div_q + 8'h01;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end
   end

   // data pin synchroniser; value changes once stages two and three agree
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         s3_q  <= 1'b0;
         din_q <= 1'b0;
      end else begin
         s1_q <= mic_data_in; // RULE_02
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            din_q <= s3_q;
      end
   end

   // output sample tick every 64 or 80 bit clocks, then filter/volume pipe
   wire [6:0] ratio = r80_q ? `PDMI_DEC80 : `PDMI_DEC64;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dc_q  <= 7'h0;
         dec_q <= 1'b0;
         pv_q  <= 1'b0;
         gv_q  <= 1'b0;
      end else begin
         pv_q <= dec_q;
         gv_q <= pv_q;
         if (!run) begin
            dc_q  <= 7'h0;
            dec_q <= 1'b0;
         end else if (rise_q && (dc_q + 7'h01 == ratio)) begin
            dc_q  <= 7'h0; // RULE_04
            dec_q <= 1'b1;
         end else begin
            dc_q  <= rise_q ? dc_q + 7'h01 : dc_q;
            dec_q <= 1'b0;
         end
      end
   end

   // per channel: third-order comb-integrator decimator and volume
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
         reg  signed [CW-1:0] i1_q, i2_q, i3_q, d1_q, d2_q, d3_q;
         reg         [15:0]   pcm_q;
         reg         [15:0]   gout_q;
         wire cap = (ch == 0) ? (edge_q ? rise_q : fall_q)
                              : (edge_q ? fall_q : rise_q); // RULE_07 RULE_08
         wire signed [CW-1:0] bit_v = {{(CW-1){~din_q}}, 1'b1};
         wire signed [CW-1:0] c1 = i3_q - d1_q;
         wire signed [CW-1:0] c2 = c1 - d2_q;
         wire signed [CW-1:0] c3 = c2 - d3_q;
         wire signed [CW-1:0] sc = r80_q ? (c3 >>> `PDMI_SH80) : (c3 >>> `PDMI_SH64);
         wire        [6:0]    vol = (ch == 0) ? lvol_q : rvol_q;
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               i1_q <= {CW{1'b0}};
               i2_q <= {CW{1'b0}};
               i3_q <= {CW{1'b0}};
               d1_q <= {CW{1'b0}};
               d2_q <= {CW{1'b0}};
               d3_q <= {CW{1'b0}};
               pcm_q  <= 16'h0;
               gout_q <= 16'h0;
            end else if (!run) begin
               i1_q <= {CW{1'b0}};
               i2_q <= {CW{1'b0}};
               i3_q <= {CW{1'b0}};
               d1_q <= {CW{1'b0}};
               d2_q <= {CW{1'b0}};
               d3_q <= {CW{1'b0}};
            end else begin
               if (cap) begin
                  i1_q <= i1_q + bit_v; // RULE_09
                  i2_q <= i2_q + i1_q;
                  i3_q <= i3_q + i2_q;
               end
               if (dec_q) begin
                  d1_q  <= i3_q;
                  d2_q  <= c1;
                  d3_q  <= c2;
                  pcm_q <= sat16({{(36-CW){sc[CW-1]}}, sc}); // RULE_03
               end
               if (pv_q)
                  gout_q <= sat16(gmul(pcm_q, vol)); // RULE_17 RULE_24
            end
         end
         assign gpair[16*ch +: 16] = gout_q; // RULE_23
      end
   endgenerate

   wire [31:0] word = mono_q ? {gpair[15:0], lsave_q} : gpair; // RULE_11 RULE_23
   wire push = gv_q & st_q[1] & (~mono_q | half_q);
   wire full = dma_req_q & dma_ack & (scnt_q >= {1'b0, cnt_q}); // RULE_22
   wire fin  = st_q[2] & ~dma_req_q;
   wire go   = st_q[0] & start_p & en_q;
   wire set_st = go | (full & st_q[1] & ~stop_p);

   // control, buffer walk, DMA and events; a hardware set beats a clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q        <= S_IDLE;
         cur_q       <= 32'h0;
         scnt_q      <= {(NW+1){1'b0}};
         half_q      <= 1'b0;
         lsave_q     <= 16'h0;
         dma_req_q   <= 1'b0;
         dma_addr_q  <= 32'h0;
         dma_wdata_q <= 32'h0;
         ev_st_q     <= 1'b0;
         ev_sp_q     <= 1'b0;
         ev_end_q    <= 1'b0;
      end else begin
         case (st_q)
            S_IDLE: if (go) begin
               st_q   <= S_RUN; // RULE_13
               cur_q  <= ptr_q;
               scnt_q <= {(NW+1){1'b0}};
               half_q <= 1'b0;
            end
            S_RUN: if (stop_p) begin
               st_q <= S_STOP; // RULE_13 RULE_14
            end else if (full) begin
               cur_q  <= ptr_q; // RULE_20 RULE_12
               scnt_q <= {(NW+1){1'b0}};
            end
            S_STOP: if (fin) begin
               st_q <= S_IDLE; // RULE_15
            end
            default: st_q <= S_IDLE;
         endcase
         if (gv_q && st_q[1] && mono_q) begin
            half_q <= ~half_q;
            if (!half_q)
               lsave_q <= gpair[15:0];
         end
         if (dma_req_q && dma_ack) begin
            dma_req_q <= 1'b0;
         end else if (push && !dma_req_q) begin
            dma_req_q   <= 1'b1; // RULE_10
            dma_wdata_q <= word;
            dma_addr_q  <= cur_q + {{(30-NW){1'b0}}, scnt_q, 1'b0}; // RULE_22
            scnt_q      <= scnt_q + 2'd2;
         end
         ev_st_q  <= set_st | ((wr_q && wa_q == `PDMI_A_EVSTART) ? hwdata[0] : ev_st_q);
         ev_sp_q  <= fin | ((wr_q && wa_q == `PDMI_A_EVSTOP) ? hwdata[0] : ev_sp_q); // RULE_14
         ev_end_q <= full | fin |
                     ((wr_q && wa_q == `PDMI_A_EVEND) ? hwdata[0] : ev_end_q); // RULE_21
      end
   end

   assign hrdata        = hrdata_q;
   assign hreadyout     = hreadyout_q;
   assign hresp         = hresp_q;
   assign mic_bit_clock = bclk_q;
   assign dma_req       = dma_req_q;
   assign dma_addr      = dma_addr_q;
   assign dma_wdata     = dma_wdata_q;

endmodule // pdmi_top

// ===== rtl/pdmi_defs.vh
`ifndef PDMI_DEFS_VH
`define PDMI_DEFS_VH
// register byte offsets
`define PDMI_A_START   12'h000
`define PDMI_A_STOP    12'h004
`define PDMI_A_EVSTART 12'h100
`define PDMI_A_EVSTOP  12'h104
`define PDMI_A_EVEND   12'h108
`define PDMI_A_STATUS  12'h400
`define PDMI_A_ENABLE  12'h500
`define PDMI_A_CLKDIV  12'h504
`define PDMI_A_MODE    12'h508
`define PDMI_A_LVOL    12'h518
`define PDMI_A_RVOL    12'h51c
`define PDMI_A_RATIO   12'h520
`define PDMI_A_PTR     12'h560
`define PDMI_A_CNT     12'h564
// field positions
`define PDMI_MODE_MONO 0
`define PDMI_MODE_EDGE 1
// reset values
`define PDMI_CLKDIV_RST 8'h62
`define PDMI_VOL_RST    7'h28
`define PDMI_RATIO_RST  1'b0
// volume limits and offset used to index the step table
`define PDMI_VOL_MAX    7'h50
`define PDMI_VOL_OFS    7'h08
// decimation factors and output scaling shifts
`define PDMI_DEC64      7'h40
`define PDMI_DEC80      7'h50
`define PDMI_SH64       3
`define PDMI_SH80       4
`endif

// ===== verif/pdmi_mic_pair.sv
`timescale 1ns/1ps
// two microphones on one shared data line
module pdmi_mic_pair #(
   parameter DLY = 2                 // output delay after an edge, ns
) (
   input  wire bclk,                 // bit clock from the block
   input  wire l_bit,                // left density bit
   input  wire r_bit,                // right density bit
   output reg  dout                  // shared data line
);
   // left drives while the clock is high, right while it is low
   always @(bclk) dout <= #(DLY) bclk ? l_bit : r_bit;
endmodule // pdmi_mic_pair

// ===== verif/pdmi_monitor.sv
`timescale 1ns/1ps
`include "pdmi_defs.vh"
// watches bus, bit clock and dma port
module pdmi_monitor (
   input wire        hclk,          // clock
   input wire        hresetn,       // reset, active low
   input wire        hsel,          // select
   input wire [31:0] haddr,         // address
   input wire [1:0]  htrans,        // transfer type
   input wire        hwrite,        // write
   input wire [2:0]  hsize,         // size
   input wire [31:0] hwdata,        // write data
   input wire        hready,        // ready in
   input wire [31:0] hrdata,        // read data
   input wire        hreadyout,     // ready out
   input wire        hresp,         // response
   input wire        mic_data_in,   // mic data
   input wire        mic_bit_clock, // bit clock
   input wire        dma_req,       // dma request
   input wire [31:0] dma_addr,      // dma address
   input wire [31:0] dma_wdata,     // dma data
   input wire        dma_ack        // dma ack
);
   reg  [11:0] a_q;
   reg         v_q, w_q;
   reg  [7:0]  div_q;
   reg  [31:0] ptr_q, st_q, nxt_q;
   reg  [8:0]  lo_q;
   wire [8:0]  half = (div_q == 8'h00) ? 9'h001 : {1'b0, div_q};
   wire        rd_ph = v_q && !w_q;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // snoop divider and pointer writes, count low phase of the bit clock
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {a_q, v_q, w_q} <= 14'h0000;
         div_q <= `PDMI_CLKDIV_RST;
         {ptr_q, st_q, nxt_q} <= 96'h0;
         lo_q <= 9'h1ff;
      end else begin
         v_q <= hsel & htrans[1] & hready;
         a_q <= haddr[11:0];
         w_q <= hwrite;
         if (v_q && w_q && a_q == `PDMI_A_CLKDIV) div_q <= hwdata[7:0];
         if (v_q && w_q && a_q == `PDMI_A_PTR) ptr_q <= hwdata;
         if (v_q && w_q && a_q == `PDMI_A_START && hwdata[0]) st_q <= ptr_q;
         if (dma_req && dma_ack) nxt_q <= dma_addr + 32'h4;
         lo_q <= mic_bit_clock ? 9'h000 : ((lo_q == 9'h1ff) ? lo_q : lo_q + 9'h001);
      end
   end
   property p_half; $rose(mic_bit_clock) && lo_q != 9'h1ff |-> lo_q == half; endproperty
   a_half: assert property (p_half) else $error("bit clock low phase wrong");
   property p_hold; dma_req && !dma_ack |=> dma_req && $stable(dma_addr) && $stable(dma_wdata);
   endproperty
   a_hold: assert property (p_hold) else $error("dma request not held");
   property p_drop; dma_req && dma_ack |=> !dma_req; endproperty
   a_drop: assert property (p_drop) else $error("dma request stays after ack");
   property p_step; $rose(dma_req) |-> dma_addr == nxt_q || dma_addr == ptr_q || dma_addr == st_q;
   endproperty
   a_step: assert property (p_step) else $error("dma address out of order");
   property p_stop; rd_ph && a_q == `PDMI_A_EVSTOP && hrdata[0] |-> !dma_req && !$past(dma_req);
   endproperty
   a_stop: assert property (p_stop) else $error("stopped with write pending");
   property p_idle; $rose(dma_req) |-> lo_q != 9'h1ff; endproperty
   a_idle: assert property (p_idle) else $error("dma word while clock idle");
   property p_rdy; hreadyout && !hresp; endproperty
   a_rdy: assert property (p_rdy) else $error("bus wait or error response");
   property p_rdz; !rd_ph |-> hrdata == 32'h0; endproperty
   a_rdz: assert property (p_rdz) else $error("read data outside data phase");
   c_word: cover property ($rose(dma_req));
   c_stop: cover property (rd_ph && a_q == `PDMI_A_EVSTOP && hrdata[0]);
   c_half: cover property ($rose(mic_bit_clock) && lo_q != 9'h1ff);
endmodule // pdmi_monitor

bind pdmi_top pdmi_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mic_data_in(mic_data_in),
   .mic_bit_clock(mic_bit_clock), .dma_req(dma_req), .dma_addr(dma_addr),
   .dma_wdata(dma_wdata), .dma_ack(dma_ack));

// ===== verif/testbench.sv
`timescale 1ns/1ps
`include "pdmi_defs.vh"
module testbench;
   logic        hclk, hresetn, hsel, hwrite, dma_ack, l_bit, r_bit, dp;
   logic [31:0] haddr, hwdata, rd, ea;
   logic [1:0]  htrans, ek;
   logic [2:0]  hsize;
   logic [15:0] lo, hi;
   wire  [31:0] hrdata, dma_addr, dma_wdata;
   wire         hready, hresp, mic_bit_clock, dma_req, mic_data_in;
   int          err_count, comparisons;
   logic [31:0] rq_e[$], rq_m[$], dq_a[$];
   logic [1:0]  dq_k[$];
   pdmi_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .mic_data_in(mic_data_in),
      .mic_bit_clock(mic_bit_clock), .dma_req(dma_req), .dma_addr(dma_addr),
      .dma_wdata(dma_wdata), .dma_ack(dma_ack));
   pdmi_mic_pair #(.DLY(2)) i_mic (.bclk(mic_bit_clock), .l_bit(l_bit), .r_bit(r_bit),
      .dout(mic_data_in));
   // clock at 200 MHz
   initial begin
      hclk = 0;
      forever #2.5 hclk = ~hclk;
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %0s expected %h seen %h", n, e, s);
      end
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one single bus transfer, read expectation noted for the negedge checker
   task ahb(input logic w, input logic [11:0] a, input logic [31:0] d, e, m);
      @(posedge hclk);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, a};
      if (!w) begin
         rq_e.push_back(e & m);
         rq_m.push_back(m);
      end
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      ahb(1, a, d, 0, 0);
   endtask
   // wait for an event bit with a bounded number of reads
   task poll(input logic [11:0] a);
      int n;
      n = 0;
      rd = 0;
      while (rd[0] !== 1'b1 && n < 800) begin
         ahb(0, a, 0, 0, 0);
         repeat (8) @(posedge hclk);
         n++;
      end
      chk("event", 1, rd[0]);
   endtask
   // compare read data and stored words with the oldest note
   always @(negedge hclk) begin
      if (dp) begin
         rd = hrdata;
         chk("hrdata", rq_e.pop_front(), hrdata & rq_m.pop_front());
      end
      dp = hsel && htrans[1] && !hwrite;
      if (dma_req === 1'b1 && dma_ack === 1'b1) begin
         if (dq_a.size() == 0) chk("dma extra", 0, 1);
         else begin
            ea = dq_a.pop_front();
            ek = dq_k.pop_front();
            {hi, lo} = dma_wdata;
            chk("dma_addr", ea, dma_addr);
            if (ek == 2'h1) chk("stereo", 1, lo == 16'h7fff && $signed(hi) < $signed(lo));
            if (ek == 2'h2) chk("mono", 32'h7fff7fff, {hi, lo});
            if (ek == 2'h3) chk("volume", 1, lo > 0 && lo < 16'h4000 && hi == 16'h7fff);
         end
      end
   end
   // memory acknowledge with a random stall
   always @(posedge hclk) begin
      if (dma_req === 1'b1 && dma_ack !== 1'b1) begin
         repeat ($urandom % 4) @(posedge hclk);
         dma_ack <= 1;
      end else dma_ack <= 0;
   end
   // one capture run that fills the first buffer and switches to the second, then stop
   task run(input string t, input logic [2:0] md, input logic [6:0] lv, rv,
            input logic [1:0] k, input logic lb, rb);
      logic [31:0] p;
      int i;
      p = $urandom & 32'h00fffff0;
      l_bit <= lb;
      r_bit <= rb;
      for (i = 0; i < 8; i++) begin
         dq_a.push_back(p + 32'h200 * (i / 4) + 32'h4 * (i % 4));
         dq_k.push_back(i < 3 ? 2'h0 : k);
      end
      wr(`PDMI_A_MODE, {30'h0, md[1:0]});
      wr(`PDMI_A_RATIO, {31'h0, md[2]});
      wr(`PDMI_A_LVOL, {25'h0, lv});
      wr(`PDMI_A_RVOL, {25'h0, rv});
      wr(`PDMI_A_PTR, p);
      wr(`PDMI_A_CNT, 32'h8);
      wr(`PDMI_A_START, 32'h1);
      ahb(0, `PDMI_A_STATUS, 0, 32'h2, 32'h7);
      wr(`PDMI_A_PTR, p + 32'h200);
      ahb(0, `PDMI_A_EVSTART, 0, 1, 1);
      wr(`PDMI_A_EVSTART, 0);
      poll(`PDMI_A_EVEND);
      ahb(0, `PDMI_A_EVSTART, 0, 1, 1);
      wr(`PDMI_A_STOP, 32'h1);
      poll(`PDMI_A_EVSTOP);
      ahb(0, `PDMI_A_STATUS, 0, 32'h1, 32'h7);
      wr(`PDMI_A_EVSTOP, 0);
      wr(`PDMI_A_EVEND, 0);
      wr(`PDMI_A_EVSTART, 0);
      dq_a.delete();
      dq_k.delete();
      repeat (600) @(posedge hclk);
      $display("test %0s done", t);
   endtask
   // reset and main sequence
   initial begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, dma_ack, l_bit, r_bit, dp} = 0;
      hsize = 3'h2;
      void'($urandom(32'hbdbb));
      repeat (3) @(posedge hclk);
      hresetn <= 1;
      @(posedge hresetn);
      ahb(0, `PDMI_A_CLKDIV, 0, 32'h62, 32'hffffffff);
      ahb(0, `PDMI_A_LVOL, 0, 32'h28, 32'hffffffff);
      ahb(0, `PDMI_A_RVOL, 0, 32'h28, 32'hffffffff);
      ahb(0, `PDMI_A_MODE, 0, 32'h0, 32'hffffffff);
      ahb(0, 12'h7f0, 0, 32'h0, 32'hffffffff);
      wr(`PDMI_A_START, 32'h1);
      ahb(0, `PDMI_A_STATUS, 0, 32'h1, 32'h7);
      $display("test reset done");
      wr(`PDMI_A_CLKDIV, 32'h4);
      wr(`PDMI_A_ENABLE, 32'h1);
      run("stereo", 3'h0, 7'h50, 7'h50, 2'h1, 1, 0);
      run("mono swap", 3'h3, 7'h50, 7'h50, 2'h2, 0, 1);
      run("volume", 3'h4, 7'h00, 7'h50, 2'h3, 1, 1);
      end_of_test;
   end
   // watchdog
   initial begin
      #200000;
      err_count++;
      end_of_test;
   end
endmodule // testbench
